// >>> bench/eaw_ext_write_tb.sv
module eaw_ext_write_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                 core_clk, rst_n, reg_wr, reg_rd, nv_req, shadow_we;
	logic [7:0]           reg_addr, reg_wdata, reg_rdata;
	eaw_pkg::eaw_nv_cfg_t nv_cfg;
	eaw_pkg::eaw_wr_t     wr_out;
	logic                 nv_done, nv_abort, err_clear, ext_warn, ext_fault, special_wr;
	logic [3:0]           special_wdata, special_rdata;
	eaw_pkg::eaw_margin_t margin_sel;
	logic                 write_busy, write_done, ab, hang, unl;
	logic [4:0]           dly;
	int                   err_count, check_count, nv_cnt, sh_cnt, cyc;

	eaw_ext_write #(.NV_WRITE_MAX_CYC(20)) dut (.core_clk(core_clk), .rst_n(rst_n),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .nv_cfg(nv_cfg), .nv_req(nv_req), .shadow_we(shadow_we),
		.wr_out(wr_out), .nv_done(nv_done), .nv_abort(nv_abort), .err_clear(err_clear),
		.ext_warn(ext_warn), .ext_fault(ext_fault), .special_wr(special_wr),
		.special_wdata(special_wdata), .special_rdata(special_rdata),
		.margin_sel(margin_sel), .write_busy(write_busy), .write_done(write_done));
	eaw_nv_model store (.core_clk(core_clk), .rst_n(rst_n), .nv_req(nv_req), .dly(dly),
		.abort_en(ab), .hang(hang), .nv_done(nv_done), .nv_abort(nv_abort));

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		nv_cnt += int'(nv_req);
		sh_cnt += int'(shadow_we);
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			report_and_stop();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("errors %0d checks %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One idle cycle after each strobe so no signal is driven twice in a time step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge core_clk);
		#1 reg_wr = 1'b0;
		@(posedge core_clk);
		#1;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_rd = 1'b1;
		reg_addr = a;
		@(posedge core_clk);
		#1 reg_rd = 1'b0;
		d = reg_rdata;
		@(posedge core_clk);
		#1;
	endtask

	// 0 refused, 1 nonvolatile, 2 shadow
	function automatic logic [1:0] kind(eaw_pkg::eaw_nv_cfg_t c, logic u, logic [7:0] a);
		logic       sh, lk, uf, ok;
		logic [7:0] b;
		sh = a[7:6] == eaw_pkg::SHADOW_TOP;
		b = sh ? a - eaw_pkg::SHADOW_OFS : a;
		lk = c.lock == eaw_pkg::LOCK_ALL || (c.lock == eaw_pkg::LOCK_NV && !sh);
		uf = b == eaw_pkg::ADR_USER_TWO || (b == eaw_pkg::ADR_USER_ONE && c.user_field_release);
		ok = lk ? uf && c.lock_bypass && (c.keycode_bypass || u) : u || (uf && c.keycode_bypass);
		return ok ? (sh ? 2'h2 : 2'h1) : 2'h0;
	endfunction

	task automatic xfer(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] k;
		logic [7:0] r;
		int         n;
		int         nb;
		int         sb;
		k = kind(nv_cfg, unl, a);
		err_clear = 1'b1;
		@(posedge core_clk);
		#1 err_clear = 1'b0;
		wr(eaw_pkg::OFS_ADDR_LO, a);
		for (int i = 0; i < 4; i++)
			wr(eaw_pkg::OFS_DATA_B3 + 8'(i), d[31-8*i -: 8]);
		nb = nv_cnt;
		sb = sh_cnt;
		reg_wr = 1'b1;
		reg_addr = eaw_pkg::OFS_CS_HI;
		reg_wdata = 8'h80;
		@(posedge core_clk);
		#1 reg_wr = 1'b0;
		chk(write_busy, 1'b1);
		chk(write_done, 1'b0);
		chk(wr_out, {a, d});
		@(posedge core_clk);
		#1 chk(nv_req, k == 2'h1);
		if (k != 2'h1)
			chk(write_done, 1'b1);
		if (k == 2'h1 && dly > 5'h7)
			wr(eaw_pkg::OFS_CS_HI, 8'h80);
		r = 8'h00;
		n = 0;
		while (r !== 8'h01 && n < 40) begin
			rd(eaw_pkg::OFS_CS_LO, r);
			n++;
		end
		chk(r, 8'h01);
		chk(nv_cnt - nb, k == 2'h1);
		chk(sh_cnt - sb, k == 2'h2);
		chk(ext_warn, k == 2'h0);
		chk(ext_fault, k == 2'h1 && (ab || hang));
		chk(write_busy, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] r, a;
		logic [3:0] s;
		void'($urandom(32'hc65f));
		{reg_wr, reg_rd, reg_addr, reg_wdata, err_clear, special_wr, special_wdata} = '0;
		{dly, ab, hang, unl} = '0;
		nv_cfg = '0;
		rst_n = 1'b0;
		repeat (2) @(posedge core_clk);
		#1 rst_n = 1'b1;
		chk({ext_warn, ext_fault, write_done, write_busy, nv_req, shadow_we, margin_sel}, '0);
		rd(8'h20, r);
		chk(r, 8'h00);
		wr(eaw_pkg::OFS_ADDR_LO, 8'h5a);
		rd(eaw_pkg::OFS_ADDR_LO, r);
		chk(r, 8'h5a);
		rd(eaw_pkg::OFS_ADDR_HI, r);
		chk(r, 8'h00);
		xfer(8'h10, 32'h00a4_5678);
		for (int i = 0; i < 50; i++) begin
			if (i == 25) begin
				wr(eaw_pkg::OFS_KEY_HI, 8'h00);
				wr(eaw_pkg::OFS_KEY_HI, 8'h55);
				for (int j = 0; j < 5; j++)
					wr(eaw_pkg::OFS_KEY_HI, eaw_pkg::KEY_SEQ[j]);
				unl = 1'b1;
			end
			nv_cfg = 7'($urandom);
			case ($urandom % 4)
				0: nv_cfg.lock = eaw_pkg::LOCK_OPEN;
				1: nv_cfg.lock = eaw_pkg::LOCK_NV;
				2: nv_cfg.lock = eaw_pkg::LOCK_ALL;
				default: ;
			endcase
			case ($urandom % 5)
				0: a = eaw_pkg::ADR_USER_TWO;
				1: a = eaw_pkg::ADR_USER_ONE;
				2: a = 8'h57;
				3: a = 8'h5f;
				default: a = {1'b0, 7'($urandom)};
			endcase
			dly = 5'($urandom % 12);
			ab = ($urandom % 6) == 0;
			hang = ($urandom % 8) == 0;
			xfer(a, $urandom);
		end
		// Codes other than the two margin settings fall back to zero on their own
		for (int i = 0; i < 6; i++) begin
			case (i)
				0, 3: s = eaw_pkg::SPECIAL_LOW;
				1: s = eaw_pkg::SPECIAL_HIGH;
				2: s = eaw_pkg::SPECIAL_NONE;
				4: s = 4'h5;
				default: s = 4'($urandom);
			endcase
			special_wr = 1'b1;
			special_wdata = s;
			@(posedge core_clk);
			#1 special_wr = 1'b0;
			repeat (3) @(posedge core_clk);
			#1 chk(special_rdata, (s == 4'h1 || s == 4'h2) ? s : 4'h0);
			chk(margin_sel, s == 4'h1 ? eaw_pkg::EAW_MARGIN_LOW
				: s == 4'h2 ? eaw_pkg::EAW_MARGIN_HIGH : eaw_pkg::EAW_MARGIN_NORMAL);
		end
		// Reset in mid-run drops both the margin setting and the keycode
		special_wr = 1'b1;
		special_wdata = eaw_pkg::SPECIAL_LOW;
		@(posedge core_clk);
		#1 special_wr = 1'b0;
		chk(margin_sel, eaw_pkg::EAW_MARGIN_LOW);
		rst_n = 1'b0;
		@(posedge core_clk);
		#1 rst_n = 1'b1;
		chk({special_rdata, margin_sel, write_done, write_busy}, '0);
		unl = 1'b0;
		nv_cfg = '0;
		xfer(eaw_pkg::ADR_USER_TWO, $urandom);
		report_and_stop();
	end
endmodule

// >>> bench/eaw_nv_model.sv
module eaw_nv_model (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       nv_req,
	input  wire logic [4:0] dly,
	input  wire logic       abort_en,
	input  wire logic       hang,
	output logic            nv_done,
	output logic            nv_abort
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] cnt;
	logic       busy;
	// A hung store never answers, so the device has to give up on its own timer
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			cnt <= 5'h0;
			nv_done <= 1'b0;
			nv_abort <= 1'b0;
		end else begin
			nv_done <= 1'b0;
			nv_abort <= 1'b0;
			if (nv_req) begin
				busy <= !hang;
				cnt <= dly;
			end else if (busy) begin
				if (cnt == 5'h0) begin
					busy <= 1'b0;
					nv_done <= !abort_en;
					nv_abort <= abort_en;
				end else begin
					cnt <= cnt - 5'h1;
				end
			end
		end
	end
endmodule

// >>> rtl/eaw_ext_write.sv
// Notes on behaviour
// RULE1 - User fields writable even under permanent lock
// RULE2 - Exception controls default to zero
// RULE3 - Unlocked lock: keycode, with user-field bypasses
// RULE4 - Locked: only user fields, via lock bypass
// RULE5 - Host first loads eight-bit target address
// RULE6 - Host then loads all 32 data bits
// RULE7 - Writing 0x80 triggers transfer of word
// RULE8 - Pollable done flag; write up to 24 ms
// RULE9 - Shadow write completes in one cycle
// RULE10 - Target address from low byte 0x03
// RULE11 - Data word assembled most significant byte first
// RULE12 - Done flag is bit 0 at 0x09
// RULE13 - Violation ends transfer, sets done and warning
// RULE14 - Aborted nonvolatile write sets fault bit
// RULE15 - Special code 0001 lowers read threshold
// RULE16 - Special code 0010 raises read threshold
// RULE17 - Margin codes persist until cleared or reset
// RULE18 - Host runs both margin passes after programming
// RULE19 - Host may margin only rewritten locations
// RULE20 - Five-byte keycode sequence unlocks until reset
// RULE21 - Shadow copies sit 0x40 above nonvolatile
// RULE22 - Lock 0xC blocks nonvolatile, 0x3 blocks both
// RULE23 - Trigger clears done; busy ignores new triggers
// RULE24 - Locked shadow write is an access violation
module eaw_ext_write #(
	parameter int unsigned NV_WRITE_MAX_CYC = eaw_pkg::NV_WRITE_MAX_CYC
) (
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	input  wire logic [7:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	output logic [7:0]                reg_rdata,
	input  wire eaw_pkg::eaw_nv_cfg_t nv_cfg,
	output logic                      nv_req,
	output logic                      shadow_we,
	output eaw_pkg::eaw_wr_t          wr_out,
	input  wire logic                 nv_done,
	input  wire logic                 nv_abort,
	input  wire logic                 err_clear,
	output logic                      ext_warn,
	output logic                      ext_fault,
	input  wire logic                 special_wr,
	input  wire logic [3:0]           special_wdata,
	output logic [3:0]                special_rdata,
	output eaw_pkg::eaw_margin_t      margin_sel,
	output logic                      write_busy,
	output logic                      write_done
);

	eaw_pkg::eaw_regs_t s_q;
	eaw_pkg::eaw_regs_t s_d;

	logic       trig;
	logic       allow;
	logic       is_shadow;
	logic       tmo;

	localparam int unsigned TMR_W = eaw_pkg::TMR_W;

	////////////////////////////////////////////////////////////////////////////////
	// Permission check on the latched target

	eaw_perm u_perm (
		.cfg       (s_q.cfg),
		.unlocked  (s_q.unlocked),
		.addr      (s_q.wr.addr),
		.allow     (allow),
		.is_shadow (is_shadow)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	assign trig = reg_wr && (reg_addr == eaw_pkg::OFS_CS_HI)
		&& reg_wdata[eaw_pkg::POS_EXECUTE_WRITE]; // RULE7
	assign tmo  = (s_q.tmr == TMR_W'(NV_WRITE_MAX_CYC - 1)); // RULE8

	always_comb begin
		s_d           = s_q;
		s_d.shadow_we = 1'b0;
		s_d.nv_req    = 1'b0;
		// Configuration follows the store, whose blank state is all zero
		s_d.cfg       = nv_cfg; // RULE2

		// Direct register writes
		if (reg_wr) begin
			case (reg_addr)
				eaw_pkg::OFS_ADDR_LO: begin
					s_d.addr = reg_wdata; // RULE5 RULE10
				end
				eaw_pkg::OFS_DATA_B3: begin
					s_d.data[31:24] = reg_wdata; // RULE6 RULE11
				end
				eaw_pkg::OFS_DATA_B2: begin
					s_d.data[23:16] = reg_wdata; // RULE11
				end
				eaw_pkg::OFS_DATA_B1: begin
					s_d.data[15:8] = reg_wdata; // RULE11
				end
				eaw_pkg::OFS_DATA_B0: begin
					s_d.data[7:0] = reg_wdata; // RULE11
				end
				eaw_pkg::OFS_KEY_HI: begin
					// A wrong byte restarts the sequence; a fresh first byte counts at once
					if (reg_wdata == eaw_pkg::KEY_SEQ[s_q.key_idx]) begin
						if (s_q.key_idx == eaw_pkg::KEY_LAST) begin
							s_d.unlocked = 1'b1; // RULE20
							s_d.key_idx  = 3'h0;
						end else begin
							s_d.key_idx = 3'(s_q.key_idx + 3'h1);
						end
					end else if (reg_wdata == eaw_pkg::KEY_SEQ[0]) begin
						s_d.key_idx = 3'h1;
					end else begin
						s_d.key_idx = 3'h0;
					end
				end
				default: begin
				end
			endcase
		end

		// Read data is registered, valid the cycle after the strobe
		if (reg_rd) begin
			case (reg_addr)
				eaw_pkg::OFS_ADDR_LO: s_d.rdata = s_q.addr; // RULE10
				eaw_pkg::OFS_DATA_B3: s_d.rdata = s_q.data[31:24];
				eaw_pkg::OFS_DATA_B2: s_d.rdata = s_q.data[23:16];
				eaw_pkg::OFS_DATA_B1: s_d.rdata = s_q.data[15:8];
				eaw_pkg::OFS_DATA_B0: s_d.rdata = s_q.data[7:0];
				eaw_pkg::OFS_CS_HI: begin
					s_d.rdata = 8'h00;
					s_d.rdata[eaw_pkg::POS_WIP] = (s_q.st != eaw_pkg::EAW_IDLE);
				end
				eaw_pkg::OFS_CS_LO: begin
					s_d.rdata = 8'h00;
					s_d.rdata[eaw_pkg::POS_WRITE_DONE] = s_q.done; // RULE12
				end
				default: s_d.rdata = 8'h00;
			endcase
		end

		// Error flags: software clear loses to a same-cycle event
		if (err_clear) begin
			s_d.warn  = 1'b0;
			s_d.fault = 1'b0;
		end

		// Write sequencer
		case (s_q.st)
			eaw_pkg::EAW_IDLE: begin
				if (trig) begin
					s_d.done    = 1'b0; // RULE23
					s_d.wr.addr = s_q.addr; // RULE7
					s_d.wr.data = s_q.data; // RULE7
					s_d.st      = eaw_pkg::EAW_SYNC;
				end
			end
			eaw_pkg::EAW_SYNC: begin
				// Triggers during a write are dropped, not queued
				if (!allow) begin
					s_d.done = 1'b1; // RULE13 RULE24
					s_d.warn = 1'b1; // RULE13
					s_d.st   = eaw_pkg::EAW_IDLE;
				end else if (is_shadow) begin
					s_d.shadow_we = 1'b1; // RULE9
					s_d.done      = 1'b1; // RULE9
					s_d.st        = eaw_pkg::EAW_IDLE;
				end else begin
					s_d.nv_req = 1'b1; // RULE7
					s_d.tmr    = '0;
					s_d.st     = eaw_pkg::EAW_NVWAIT;
				end
			end
			eaw_pkg::EAW_NVWAIT: begin
				if (nv_done) begin
					s_d.done = 1'b1; // RULE8
					s_d.st   = eaw_pkg::EAW_IDLE;
				end else if (nv_abort || tmo) begin
					// A store that never answers is treated as an aborted write
					s_d.done  = 1'b1; // RULE8
					s_d.fault = 1'b1; // RULE14
					s_d.st    = eaw_pkg::EAW_IDLE;
				end else begin
					s_d.tmr = TMR_W'(s_q.tmr + 1'b1);
				end
			end
			default: begin
				s_d.st = eaw_pkg::EAW_IDLE;
			end
		endcase

		// Margin codes stay; any other code acts for one cycle only
		if (special_wr) begin
			s_d.special = special_wdata; // RULE17
		end else if ((s_q.special != eaw_pkg::SPECIAL_LOW)
			&& (s_q.special != eaw_pkg::SPECIAL_HIGH)) begin
			s_d.special = eaw_pkg::SPECIAL_NONE; // RULE17
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q          <= '0;
			s_q.st       <= eaw_pkg::EAW_IDLE;
			s_q.addr     <= eaw_pkg::RST_ADDR;
			s_q.data     <= eaw_pkg::RST_DATA;
			s_q.unlocked <= 1'b0; // RULE20
			s_q.cfg      <= '0; // RULE2
			s_q.special  <= eaw_pkg::SPECIAL_NONE;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	always_comb begin
		case (s_q.special)
			eaw_pkg::SPECIAL_LOW:  margin_sel = eaw_pkg::EAW_MARGIN_LOW; // RULE15
			eaw_pkg::SPECIAL_HIGH: margin_sel = eaw_pkg::EAW_MARGIN_HIGH; // RULE16
			default:               margin_sel = eaw_pkg::EAW_MARGIN_NORMAL;
		endcase
	end

	assign reg_rdata     = s_q.rdata;
	assign nv_req        = s_q.nv_req;
	assign shadow_we     = s_q.shadow_we;
	assign wr_out        = s_q.wr;
	assign ext_warn      = s_q.warn;
	assign ext_fault     = s_q.fault;
	assign special_rdata = s_q.special;
	assign write_busy    = (s_q.st != eaw_pkg::EAW_IDLE);
	assign write_done    = s_q.done;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	property p_user_two_under_lock;
		@(posedge core_clk) disable iff (!rst_n)
		(s_q.st == eaw_pkg::EAW_SYNC) && (s_q.cfg.lock == eaw_pkg::LOCK_NV)
			&& s_q.cfg.lock_bypass && s_q.cfg.keycode_bypass
			&& (s_q.wr.addr == eaw_pkg::ADR_USER_TWO)
		|=> nv_req && write_busy;
	endproperty
	a_user_two_under_lock: assert property (p_user_two_under_lock) // RULE1
		else $error("user field two not opened under lock with bypasses");

	property p_open_needs_key;
		@(posedge core_clk) disable iff (!rst_n)
		(s_q.st == eaw_pkg::EAW_SYNC) && (s_q.cfg.lock == eaw_pkg::LOCK_OPEN)
			&& !s_q.unlocked && !s_q.cfg.keycode_bypass
		|=> !nv_req && !shadow_we && write_done && ext_warn && !write_busy;
	endproperty
	a_open_needs_key: assert property (p_open_needs_key) // RULE3
		else $error("write without keycode was not refused");

	property p_lock_blocks_general;
		@(posedge core_clk) disable iff (!rst_n)
		(s_q.st == eaw_pkg::EAW_SYNC) && (s_q.cfg.lock == eaw_pkg::LOCK_NV)
			&& !s_q.cfg.lock_bypass && (s_q.wr.addr[7:6] == 2'h0)
		|=> !nv_req ##1 !nv_req;
	endproperty
	a_lock_blocks_general: assert property (p_lock_blocks_general) // RULE4
		else $error("nonvolatile write passed the lock");

	property p_trigger_starts;
		@(posedge core_clk) disable iff (!rst_n)
		trig && !write_busy
		|=> write_busy && !write_done && (wr_out.data == $past(s_q.data));
	endproperty
	a_trigger_starts: assert property (p_trigger_starts) // RULE7
		else $error("trigger did not start a write of the loaded word");

	property p_nv_bounded;
		@(posedge core_clk) disable iff (!rst_n)
		(s_q.st == eaw_pkg::EAW_NVWAIT) |-> (s_q.tmr < TMR_W'(NV_WRITE_MAX_CYC));
	endproperty
	a_nv_bounded: assert property (p_nv_bounded) // RULE8
		else $error("nonvolatile write outlived its time limit");

	property p_shadow_one_cycle;
		@(posedge core_clk) disable iff (!rst_n)
		(s_q.st == eaw_pkg::EAW_SYNC) && allow && is_shadow
		|=> shadow_we && write_done && !write_busy ##1 !shadow_we;
	endproperty
	a_shadow_one_cycle: assert property (p_shadow_one_cycle) // RULE9
		else $error("shadow write did not finish in one cycle");

	property p_msb_first;
		@(posedge core_clk) disable iff (!rst_n)
		reg_wr && (reg_addr == eaw_pkg::OFS_DATA_B3)
		|=> s_q.data[31:24] == $past(reg_wdata);
	endproperty
	a_msb_first: assert property (p_msb_first) // RULE11
		else $error("first data byte not placed in bits 31 to 24");

	property p_done_readback;
		@(posedge core_clk) disable iff (!rst_n)
		reg_rd && (reg_addr == eaw_pkg::OFS_CS_LO)
		|=> reg_rdata == {7'h00, $past(s_q.done)};
	endproperty
	a_done_readback: assert property (p_done_readback) // RULE12
		else $error("done flag not returned in bit 0");

	property p_abort_fault;
		@(posedge core_clk) disable iff (!rst_n)
		(s_q.st == eaw_pkg::EAW_NVWAIT) && !nv_done && nv_abort
		|=> ext_fault && write_done && !write_busy;
	endproperty
	a_abort_fault: assert property (p_abort_fault) // RULE14
		else $error("aborted write did not raise the fault bit");

	property p_margin_persists;
		@(posedge core_clk) disable iff (!rst_n)
		special_wr && (special_wdata == eaw_pkg::SPECIAL_HIGH)
		##1 !special_wr [*3]
		|-> margin_sel == eaw_pkg::EAW_MARGIN_HIGH;
	endproperty
	a_margin_persists: assert property (p_margin_persists) // RULE16 RULE17
		else $error("high margin setting did not persist");

	property p_shadow_full_lock;
		@(posedge core_clk) disable iff (!rst_n)
		(s_q.st == eaw_pkg::EAW_SYNC) && (s_q.cfg.lock == eaw_pkg::LOCK_ALL)
			&& !s_q.cfg.lock_bypass && is_shadow
		|=> !shadow_we && ext_warn && write_done;
	endproperty
	a_shadow_full_lock: assert property (p_shadow_full_lock) // RULE22 RULE24
		else $error("shadow write passed the full lock");

	property p_busy_ignores_trigger;
		@(posedge core_clk) disable iff (!rst_n)
		trig && write_busy
		|=> $stable(wr_out);
	endproperty
	a_busy_ignores_trigger: assert property (p_busy_ignores_trigger) // RULE23
		else $error("trigger during a write changed the target");

	property p_keycode_unlocks;
		@(posedge core_clk) disable iff (!rst_n)
		reg_wr && (reg_addr == eaw_pkg::OFS_KEY_HI) && (s_q.key_idx == eaw_pkg::KEY_LAST)
			&& (reg_wdata == eaw_pkg::KEY_SEQ[eaw_pkg::KEY_LAST])
		|=> s_q.unlocked;
	endproperty
	a_keycode_unlocks: assert property (p_keycode_unlocks) // RULE20
		else $error("full keycode sequence did not unlock");

	property p_low_margin;
		@(posedge core_clk) disable iff (!rst_n)
		special_wr && (special_wdata == eaw_pkg::SPECIAL_LOW)
		|=> (margin_sel == eaw_pkg::EAW_MARGIN_LOW) && (special_rdata == eaw_pkg::SPECIAL_LOW);
	endproperty
	a_low_margin: assert property (p_low_margin) // RULE15
		else $error("low margin setting not applied");

endmodule

// >>> rtl/eaw_perm.sv
module eaw_perm (
	input  wire eaw_pkg::eaw_nv_cfg_t cfg,
	input  wire logic                 unlocked,
	input  wire logic [7:0]           addr,
	output logic                      allow,
	output logic                      is_shadow
);

	logic [7:0] base;
	logic       locked;
	logic       user_ok;

	always_comb begin
		is_shadow = (addr[7:6] == eaw_pkg::SHADOW_TOP);
		base      = is_shadow ? 8'(addr - eaw_pkg::SHADOW_OFS) : addr; // RULE21
		// Shadow memory is only frozen by the stronger lock value
		if (is_shadow) begin
			locked = (cfg.lock == eaw_pkg::LOCK_ALL); // RULE22
		end else begin
			locked = (cfg.lock == eaw_pkg::LOCK_NV) || (cfg.lock == eaw_pkg::LOCK_ALL); // RULE22
		end
		user_ok = (base == eaw_pkg::ADR_USER_TWO)
			|| ((base == eaw_pkg::ADR_USER_ONE) && cfg.user_field_release);
		if (!locked) begin
			allow = unlocked || (user_ok && cfg.keycode_bypass); // RULE3
		end else begin
			// Under lock only the user fields can open, and only with the bypass
			allow = user_ok && cfg.lock_bypass && (cfg.keycode_bypass || unlocked); // RULE1 RULE4
		end
	end

endmodule

// >>> rtl/eaw_pkg.sv
package eaw_pkg;

	// Direct register byte addresses
	localparam logic [7:0] OFS_ADDR_HI = 8'h02;
	localparam logic [7:0] OFS_ADDR_LO = 8'h03;
	localparam logic [7:0] OFS_DATA_B3 = 8'h04;
	localparam logic [7:0] OFS_DATA_B2 = 8'h05;
	localparam logic [7:0] OFS_DATA_B1 = 8'h06;
	localparam logic [7:0] OFS_DATA_B0 = 8'h07;
	localparam logic [7:0] OFS_CS_HI   = 8'h08;
	localparam logic [7:0] OFS_CS_LO   = 8'h09;
	localparam logic [7:0] OFS_KEY_HI  = 8'h3c;

	// Field positions
	localparam int unsigned POS_EXECUTE_WRITE = 7;
	localparam int unsigned POS_WIP           = 0;
	localparam int unsigned POS_WRITE_DONE    = 0;

	// Unlock byte sequence, first byte in entry 0
	localparam int unsigned         KEY_LEN  = 5;
	localparam logic [4:0][7:0]     KEY_SEQ  = {8'h77, 8'h1f, 8'h81, 8'h27, 8'h00};
	localparam logic [2:0]          KEY_LAST = 3'h4;

	// Lock field values
	localparam logic [3:0] LOCK_OPEN = 4'h0;
	localparam logic [3:0] LOCK_NV   = 4'hc;
	localparam logic [3:0] LOCK_ALL  = 4'h3;

	// Extended address map
	localparam logic [7:0] ADR_USER_TWO = 8'h17;
	localparam logic [7:0] ADR_USER_ONE = 8'h1f;
	localparam logic [7:0] SHADOW_OFS   = 8'h40;
	localparam logic [1:0] SHADOW_TOP   = 2'h1;

	// Special-function codes
	localparam logic [3:0] SPECIAL_NONE = 4'h0;
	localparam logic [3:0] SPECIAL_LOW  = 4'h1;
	localparam logic [3:0] SPECIAL_HIGH = 4'h2;

	// Longest nonvolatile write time, rounded down to whole cycles
	localparam int unsigned CLK_HZ           = 25_000_000;
	localparam int unsigned NV_WRITE_MAX_MS  = 24;
	localparam int unsigned NV_WRITE_MAX_CYC = NV_WRITE_MAX_MS * (CLK_HZ / 1000);
	localparam int unsigned TMR_W            = 24;

	// Reset values
	localparam logic [7:0]  RST_ADDR = 8'h00;
	localparam logic [31:0] RST_DATA = 32'h0000_0000;

	typedef enum logic [1:0] {
		EAW_IDLE   = 2'b00,
		EAW_SYNC   = 2'b01,
		EAW_NVWAIT = 2'b10
	} eaw_state_t;

	typedef enum logic [1:0] {
		EAW_MARGIN_NORMAL = 2'b00,
		EAW_MARGIN_LOW    = 2'b01,
		EAW_MARGIN_HIGH   = 2'b10
	} eaw_margin_t;

	typedef struct packed {
		logic [3:0] lock;
		logic       user_field_release;
		logic       lock_bypass;
		logic       keycode_bypass;
	} eaw_nv_cfg_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] data;
	} eaw_wr_t;

	typedef struct packed {
		eaw_state_t        st;
		logic [7:0]        addr;
		logic [31:0]       data;
		eaw_wr_t           wr;
		logic              done;
		logic [2:0]        key_idx;
		logic              unlocked;
		eaw_nv_cfg_t       cfg;
		logic [TMR_W-1:0]  tmr;
		logic              warn;
		logic              fault;
		logic [3:0]        special;
		logic [7:0]        rdata;
		logic              shadow_we;
		logic              nv_req;
	} eaw_regs_t;

endpackage
